// file: common/rbw_pkg.sv
package rbw_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 50_000_000;  // ref_clk rate
    localparam int unsigned STALL_TIME_S = 30;  // Heartbeat stall limit in seconds
    localparam longint unsigned STALL_CYCLES = longint'(STALL_TIME_S) * longint'(CLK_HZ);
    localparam int unsigned STALL_W = 32;  // Width of stall counter

    // ------------------------------------------------------------
    // Drive layout and indicator positions
    // ------------------------------------------------------------
    localparam int unsigned NUM_IND = 16;  // Status indicators
    localparam int unsigned NUM_VALVE = 8;  // Two driver groups of four
    localparam int unsigned VALVE_GROUP = 4;  // Valves per driver group
    localparam int unsigned V_MEAS_REF = 0;  // Valve slot: measure/reference selector
    localparam int unsigned V_ZERO_AIR_SHUT = 1;  // Valve slot: zero-air shutoff
    localparam int unsigned V_DIVERT = 2;  // Valve slot: divert
    localparam int unsigned V_GEN = 3;  // Valve slot: generator valve
    localparam int unsigned IX_HEART = 0;  // Indicator index (position one)
    localparam int unsigned IX_ZERO_AIR_PUMP = 1;
    localparam int unsigned IX_MEAS_REF = 6;
    localparam int unsigned IX_ZERO_AIR_SHUT = 7;
    localparam int unsigned IX_OZ_PUMP = 8;
    localparam int unsigned IX_DIVERT = 9;
    localparam int unsigned IX_GEN_VALVE = 10;
    localparam int unsigned IX_PHOTO_HTR = 14;
    localparam int unsigned IX_GEN_HTR = 15;
    localparam logic [15:0] IND_SPARE_MASK = 16'h383c;  // Positions 3-6 and 12-14, bits 2-5 and 11-13
    localparam logic [7:0] VALVE_RST = 8'h00;  // All valves closed
    localparam logic STALL_COUNT_RST = 1'b0;

    // ------------------------------------------------------------
    // Host command (decoded I2C write) carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic heartbeat;  // Heartbeat indicator level
        logic zero_air_pump;  // Optional zero-air AC pump
        logic ozone_pump;  // Ozone pump
        logic photo_heater;  // Photometer lamp heater
        logic gen_heater;  // Generator lamp heater
        logic [7:0] valves;  // Valve drives, group 0 in [3:0]
    } rbw_cmd_s;

    // Safe-state machine
    typedef enum logic [1:0] {
        RBW_RUN = 2'b00,
        RBW_SAFE = 2'b01
    } rbw_state_e;
endpackage

// file: verilog/rbw_stall_timer.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Stall timer: counts cycles since the last heartbeat change
// ------------------------------------------------------------
module rbw_stall_timer #(
    parameter longint unsigned LIMIT = rbw_pkg::STALL_CYCLES,
    parameter int unsigned W = rbw_pkg::STALL_W
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic restart,
    output logic expired
);
    import rbw_pkg::*;

    // Elaboration check: the limit must fit the counter and leave room to count
    if (LIMIT < 2 || LIMIT >= (64'h1 << W)) begin : g_bad_limit
        $error("rbw_stall_timer: LIMIT does not fit counter");
    end

    logic [W-1:0] cnt_q;  // Cycles without a change
    logic [W-1:0] cnt_d;
    logic exp_q;  // Limit reached
    logic exp_d;

    // Next count: restart on change, hold at LIMIT - 1 and flag expiry
    always_comb begin
        cnt_d = cnt_q;
        exp_d = exp_q;
        if (restart) begin
            cnt_d = '0;
            exp_d = 1'b0;
        end else if (cnt_q == W'(LIMIT - 1)) begin
            exp_d = 1'b1;
        end else begin
            cnt_d = cnt_q + W'(1);
        end
    end

    // Registers only
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
            exp_q <= STALL_COUNT_RST;
        end else begin
            cnt_q <= cnt_d;
            exp_q <= exp_d;
        end
    end

    assign expired = exp_q;

    a_restart_clears: assert property (@(posedge ref_clk) disable iff (!resetn)
        restart |=> (cnt_q == '0 && !exp_q)) else $error("restart did not clear timer");
endmodule  // rbw_stall_timer

// file: verilog/rbw_relay_watchdog.sv
`timescale 1ns/1ns
// Operation
// - Sixteen indicators; spares never active
// - Watchdog monitors heartbeat level independently
// - 30 s stuck heartbeat forces all drives off
// - Indicator two follows zero-air pump
// - Indicator seven lit on measure path
// - Indicator eight follows zero-air shutoff valve
// - Indicator nine follows ozone pump
// - Indicator ten follows divert valve
// - Indicator eleven follows generator valve
// - Indicator fifteen follows photometer heater
// - Indicator sixteen follows generator heater
// - Eight valve drives, two groups four
module rbw_relay_watchdog #(
    parameter longint unsigned STALL_LIMIT = rbw_pkg::STALL_CYCLES
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic cmd_valid,
    input rbw_pkg::rbw_cmd_s cmd,
    output logic [15:0] indicators,
    output logic [7:0] valve_drive,
    output logic zero_air_pump_drive,
    output logic ozone_pump_drive,
    output logic photo_heater_drive,
    output logic gen_heater_drive,
    output logic safe_off
);
    import rbw_pkg::*;

    // Elaboration check: two groups of four valves and a usable stall limit
    if (NUM_VALVE != 2 * VALVE_GROUP || STALL_LIMIT < 2) begin : g_bad_config
        $error("rbw_relay_watchdog: unsupported configuration");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    rbw_cmd_s req_q;  // Latest host settings
    rbw_cmd_s req_d;
    rbw_state_e st_q;  // Run or latched safe-off
    rbw_state_e st_d;
    logic hb_prev_q;  // Heartbeat level one cycle back
    logic hb_prev_d;
    logic [15:0] ind_q;
    logic [15:0] ind_d;
    logic [7:0] valve_q;
    logic [7:0] valve_d;
    logic [3:0] pwr_q;  // Zero-air pump, ozone pump, photo heater, gen heater
    logic [3:0] pwr_d;
    logic safe_q;  // Registered copy of the latched trip
    logic safe_d;
    logic hb_change;
    logic stall_expired;

    // Separate timer watches the level, not the write strobe, so
    // rewriting the same level does not count as a heartbeat
    assign hb_change = (req_q.heartbeat != hb_prev_q);

    rbw_stall_timer #(
        .LIMIT(STALL_LIMIT),
        .W(STALL_W)
    ) rbw_stall_timer_i (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .restart(hb_change),
        .expired(stall_expired)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        req_d = req_q;
        if (cmd_valid) begin
            req_d = cmd;
        end
        hb_prev_d = req_q.heartbeat;
        case (st_q)
            RBW_RUN: begin
                st_d = stall_expired ? RBW_SAFE : RBW_RUN;
            end
            RBW_SAFE: begin
                st_d = RBW_SAFE;  // held until reset
            end
            default: begin
                st_d = RBW_SAFE;
            end
        endcase
        // Own flop so the output does not hang off a state decoder
        safe_d = (st_d == RBW_SAFE);
        // Safe state overrides every drive; heartbeat still shows
        if (safe_d) begin
            valve_d = VALVE_RST;
            pwr_d = 4'h0;
        end else begin
            valve_d = req_d.valves;
            pwr_d = {req_d.zero_air_pump, req_d.ozone_pump, req_d.photo_heater, req_d.gen_heater};
        end
        // Indicators mirror the drives as actually applied
        ind_d = 16'h0000;
        ind_d[IX_HEART] = req_d.heartbeat;
        ind_d[IX_ZERO_AIR_PUMP] = pwr_d[3];
        ind_d[IX_MEAS_REF] = valve_d[V_MEAS_REF];
        ind_d[IX_ZERO_AIR_SHUT] = valve_d[V_ZERO_AIR_SHUT];
        ind_d[IX_OZ_PUMP] = pwr_d[2];
        ind_d[IX_DIVERT] = valve_d[V_DIVERT];
        ind_d[IX_GEN_VALVE] = valve_d[V_GEN];
        ind_d[IX_PHOTO_HTR] = pwr_d[1];
        ind_d[IX_GEN_HTR] = pwr_d[0];
        ind_d = ind_d & ~IND_SPARE_MASK;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            req_q <= '0;
            st_q <= RBW_RUN;
            hb_prev_q <= 1'b0;
            ind_q <= 16'h0000;
            valve_q <= VALVE_RST;
            pwr_q <= 4'h0;
            safe_q <= 1'b0;
        end else begin
            req_q <= req_d;
            st_q <= st_d;
            hb_prev_q <= hb_prev_d;
            ind_q <= ind_d;
            valve_q <= valve_d;
            pwr_q <= pwr_d;
            safe_q <= safe_d;
        end
    end

    assign indicators = ind_q;
    assign valve_drive = valve_q;
    assign zero_air_pump_drive = pwr_q[3];
    assign ozone_pump_drive = pwr_q[2];
    assign photo_heater_drive = pwr_q[1];
    assign gen_heater_drive = pwr_q[0];
    assign safe_off = safe_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_spares_dark: assert property (@(posedge ref_clk) disable iff (!resetn)
        (ind_q & IND_SPARE_MASK) == 16'h0000) else $error("spare indicator lit");
    a_safe_all_off: assert property (@(posedge ref_clk) disable iff (!resetn)
        safe_off |-> (valve_q == 8'h00 && pwr_q == 4'h0)) else $error("drive on in safe state");
    a_safe_latched: assert property (@(posedge ref_clk) disable iff (!resetn)
        safe_off |=> safe_off) else $error("safe state released");
    a_stall_enters_safe: assert property (@(posedge ref_clk) disable iff (!resetn)
        stall_expired |=> safe_off) else $error("stall did not force safe state");
    a_toggle_keeps_run: assert property (@(posedge ref_clk) disable iff (!resetn)
        (!safe_off && hb_change) |=> !stall_expired) else $error("timer not restarted");
    a_zero_air_pump_ind: assert property (@(posedge ref_clk) disable iff (!resetn)
        ind_q[IX_ZERO_AIR_PUMP] == zero_air_pump_drive) else $error("indicator two mismatch");
    a_meas_ind: assert property (@(posedge ref_clk) disable iff (!resetn)
        ind_q[IX_MEAS_REF] == valve_q[V_MEAS_REF]) else $error("indicator seven mismatch");
    a_shutoff_ind: assert property (@(posedge ref_clk) disable iff (!resetn)
        ind_q[IX_ZERO_AIR_SHUT] == valve_q[V_ZERO_AIR_SHUT]) else $error("indicator eight mismatch");
    a_ozpump_ind: assert property (@(posedge ref_clk) disable iff (!resetn)
        ind_q[IX_OZ_PUMP] == ozone_pump_drive) else $error("indicator nine mismatch");
    a_divert_ind: assert property (@(posedge ref_clk) disable iff (!resetn)
        ind_q[IX_DIVERT] == valve_q[V_DIVERT]) else $error("indicator ten mismatch");
    a_genvalve_ind: assert property (@(posedge ref_clk) disable iff (!resetn)
        ind_q[IX_GEN_VALVE] == valve_q[V_GEN]) else $error("indicator eleven mismatch");
    a_photo_htr_ind: assert property (@(posedge ref_clk) disable iff (!resetn)
        ind_q[IX_PHOTO_HTR] == photo_heater_drive) else $error("indicator fifteen mismatch");
    a_gen_htr_ind: assert property (@(posedge ref_clk) disable iff (!resetn)
        ind_q[IX_GEN_HTR] == gen_heater_drive) else $error("indicator sixteen mismatch");
    a_valve_follow: assert property (@(posedge ref_clk) disable iff (!resetn)
        (cmd_valid && !safe_off && !stall_expired) |=> (valve_q == $past(cmd.valves)))
        else $error("valve drive not applied");
endmodule  // rbw_relay_watchdog

// file: tb/rbw_host_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Host model: decoded bus writes to the relay board
// ------------------------------------------------------------
module rbw_host_model (
    input wire logic ref_clk,
    output logic cmd_valid,
    output rbw_pkg::rbw_cmd_s cmd
);
    import rbw_pkg::*;
    logic hb_q;  // Last heartbeat level sent
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
        hb_q = 1'b0;
    end
    // One write; hold leaves the strobe up for a back-to-back follower
    task automatic write(input rbw_cmd_s c, input bit toggle, input bit hold, output rbw_cmd_s sent);
        sent = c;
        sent.heartbeat = toggle ? ~hb_q : hb_q;
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd <= sent;
        hb_q = sent.heartbeat;
        if (!hold) begin
            @(posedge ref_clk);
            cmd_valid <= 1'b0;
            // Idle bus shows the inverse, so a stale copy cannot pass
            cmd <= ~sent;
        end
    endtask
endmodule // rbw_host_model

// file: tb/rbw_relay_watchdog_bench.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Bench: host writes, heartbeat stall and reset behaviour
// ------------------------------------------------------------
module rbw_relay_watchdog_bench;
    import rbw_pkg::*;
    localparam longint unsigned LIM = 20;  // Short stall limit keeps the run brief
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic cmd_valid;
    rbw_cmd_s cmd;
    rbw_cmd_s last_c;  // Last command sent
    logic [15:0] indicators;
    logic [7:0] valve_drive;
    logic zero_air_d, oz_d, ph_d, gh_d, safe_off;
    logic took_q = 1'b0;  // A write was taken last edge
    logic [28:0] exp_q[$];  // Expected results, oldest first
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    wire [28:0] seen = {indicators, valve_drive, zero_air_d, oz_d, ph_d, gh_d, safe_off};
    always #10 ref_clk = ~ref_clk;
    rbw_host_model rbw_host_model_i (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd(cmd));
    rbw_relay_watchdog #(.STALL_LIMIT(LIM)) rbw_relay_watchdog_i (
        .ref_clk(ref_clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd(cmd),
        .indicators(indicators), .valve_drive(valve_drive), .zero_air_pump_drive(zero_air_d),
        .ozone_pump_drive(oz_d), .photo_heater_drive(ph_d), .gen_heater_drive(gh_d), .safe_off(safe_off));
    // ------------------------------------------------------------
    // Expected outputs; safe state darkens all but the heartbeat
    // ------------------------------------------------------------
    function automatic logic [28:0] exp_of(input rbw_cmd_s c, input logic s);
        logic [15:0] ind;
        logic [7:0] v;
        v = s ? 8'h00 : c.valves;
        ind = 16'h0000;
        ind[IX_HEART] = c.heartbeat;
        ind[IX_ZERO_AIR_PUMP] = c.zero_air_pump & ~s;
        ind[IX_MEAS_REF] = v[V_MEAS_REF];
        ind[IX_ZERO_AIR_SHUT] = v[V_ZERO_AIR_SHUT];
        ind[IX_OZ_PUMP] = c.ozone_pump & ~s;
        ind[IX_DIVERT] = v[V_DIVERT];
        ind[IX_GEN_VALVE] = v[V_GEN];
        ind[IX_PHOTO_HTR] = c.photo_heater & ~s;
        ind[IX_GEN_HTR] = c.gen_heater & ~s;
        return {ind, v, c.zero_air_pump & ~s, c.ozone_pump & ~s, c.photo_heater & ~s, c.gen_heater & ~s, s};
    endfunction
    task automatic chk(input string n, input logic [28:0] e, input logic [28:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    // Random write, result noted for the watcher
    task automatic send(input bit hold, input bit toggle, input logic s);
        logic [12:0] r;
        r = 13'($urandom);
        rbw_host_model_i.write(rbw_cmd_s'(r), toggle, hold, last_c);
        exp_q.push_back(exp_of(last_c, s));
    endtask
    task automatic tally_and_finish;
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Watcher: results appear on the taking edge and are checked at the falling edge after it
    // ------------------------------------------------------------
    always @(posedge ref_clk) took_q <= cmd_valid & resetn;
    always @(negedge ref_clk) begin
        if (took_q && exp_q.size() > 0) chk("write result", exp_q.pop_front(), seen);
    end
    // Hang guard, far above the planned run length
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h8a0c));
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        @(negedge ref_clk) chk("reset outputs", 29'h0, seen);
        for (int i = 0; i < 40; i++) send(i < 39, 1'b1, 1'b0);
        for (int i = 0; i < 8; i++) begin
            send(1'b0, 1'b1, 1'b0);
            repeat (12) @(posedge ref_clk);
        end
        // Same-level writes must not restart the stall count
        send(1'b0, 1'b1, 1'b0);
        repeat (6) @(posedge ref_clk);
        send(1'b0, 1'b0, 1'b0);
        repeat (6) @(posedge ref_clk);
        send(1'b0, 1'b0, 1'b0);
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk) chk("stall trip", exp_of(last_c, 1'b1), seen);
        send(1'b0, 1'b1, 1'b1);
        repeat (30) @(posedge ref_clk);
        @(negedge ref_clk) chk("latched safe", exp_of(last_c, 1'b1), seen);
        // Reset in mid-run clears the trip
        @(posedge ref_clk) resetn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk) chk("in reset", 29'h0, seen);
        @(posedge ref_clk) resetn <= 1'b1;
        @(negedge ref_clk) chk("after reset", 29'h0, seen);
        rbw_host_model_i.hb_q = 1'b0;
        send(1'b0, 1'b1, 1'b0);
        repeat (4) @(posedge ref_clk);
        // Every noted result must have been taken off and compared
        chk("pending results", 29'h0, 29'(exp_q.size()));
        tally_and_finish();
    end
endmodule // rbw_relay_watchdog_bench
